/* File: design/bgp_packer.sv */
// green/blue-first twelve-bit packed mosaic pixel packer, top level
// assumes pixel source and byte sink share sys_clk with valid/ready flow
`timescale 1ns/100ps
module bgp_packer (
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic               green_blue_first_twelve_bit_packed_mode,
    input  wire logic               pix_valid,
    output logic                    pix_ready,
    input  wire bgp_pkg::bgp_pix_t  pix_in,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output bgp_pkg::bgp_byte_t      out_byte,
    output logic                    line_odd,
    output logic [15:0]             line_count,
    output logic                    odd_tail
);
    import bgp_pkg::*;

    typedef enum logic [1:0] {
        BGP_ST_FIRST  = 2'h0,
        BGP_ST_SECOND = 2'h1,
        BGP_ST_FLUSH  = 2'h2
    } bgp_state_t;

    bgp_state_t       state_r;
    bgp_state_t       state_nxt;
    logic [11:0]      early_r;
    logic [11:0]      early_nxt;
    logic             first_r;
    logic             first_nxt;
    logic             line_odd_r;
    logic             line_odd_nxt;
    logic             grp_odd_r;
    logic             grp_odd_nxt;
    logic [CNT_W-1:0] line_cnt_r;
    logic [CNT_W-1:0] line_cnt_nxt;
    logic             tail_r;
    logic             tail_nxt;
    logic             pix_acc;
    logic             grp_valid;
    logic             grp_ready;
    bgp_grp_t         grp;
    logic [11:0]      sample;

    // samples are taken as a bare twelve-bit unsigned code
    assign sample = pix_in.data & PIX_MAX;

    assign pix_ready = green_blue_first_twelve_bit_packed_mode
                       && (state_r == BGP_ST_FIRST
                           || (state_r == BGP_ST_SECOND && grp_ready));
    assign pix_acc   = pix_valid && pix_ready;

    always_comb begin
        grp       = '0;
        grp_valid = 1'b0;
        grp.early = early_r;
        grp.odd_line = grp_odd_r;
        grp.first = first_r;
        if (state_r == BGP_ST_SECOND) begin
            grp_valid = pix_valid && green_blue_first_twelve_bit_packed_mode;
            grp.late  = sample;
            grp.last  = pix_in.eol;
        end else if (state_r == BGP_ST_FLUSH) begin
            // a line that ends on an earlier pixel is closed with a zero mate
            grp_valid = 1'b1;
            grp.late  = PIX_ZERO;
            grp.last  = 1'b1;
        end
    end

    always_comb begin
        state_nxt    = state_r;
        early_nxt    = early_r;
        first_nxt    = first_r;
        line_odd_nxt = line_odd_r;
        grp_odd_nxt  = grp_odd_r;
        line_cnt_nxt = line_cnt_r;
        tail_nxt     = 1'b0;
        if (pix_acc) begin
            if (pix_in.sof) begin
                line_odd_nxt = 1'b0;
                line_cnt_nxt = '0;
            end
            if (state_r == BGP_ST_FIRST) begin
                early_nxt   = sample;
                grp_odd_nxt = pix_in.sof ? 1'b0 : line_odd_r;
                state_nxt   = pix_in.eol ? BGP_ST_FLUSH : BGP_ST_SECOND;
            end else begin
                state_nxt = BGP_ST_FIRST;
                first_nxt = 1'b0;
            end
            if (pix_in.eol) begin
                line_odd_nxt = ~(pix_in.sof ? 1'b0 : line_odd_r);
                line_cnt_nxt = (pix_in.sof ? '0 : line_cnt_r)
                               + CNT_W'(1);
                // an odd tail keeps its group flags until the flush leaves
                if (state_r == BGP_ST_SECOND) begin
                    first_nxt = 1'b1;
                end
                tail_nxt     = (state_r == BGP_ST_FIRST);
            end
        end else if (state_r == BGP_ST_FLUSH && grp_ready) begin
            state_nxt = BGP_ST_FIRST;
            first_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_r    <= BGP_ST_FIRST;
            early_r    <= PIX_ZERO;
            first_r    <= 1'b1;
            line_odd_r <= 1'b0;
            grp_odd_r  <= 1'b0;
            line_cnt_r <= '0;
            tail_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            early_r    <= early_nxt;
            first_r    <= first_nxt;
            line_odd_r <= line_odd_nxt;
            grp_odd_r  <= grp_odd_nxt;
            line_cnt_r <= line_cnt_nxt;
            tail_r     <= tail_nxt;
        end
    end

    assign line_odd   = line_odd_r;
    assign line_count = line_cnt_r;
    assign odd_tail   = tail_r;

    bgp_byte_emitter u_emit (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .grp_valid (grp_valid),
        .grp_ready (grp_ready),
        .grp_in    (grp),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_byte  (out_byte)
    );

    a_raw_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && state_r == BGP_ST_FIRST |=>
            early_r == $past(pix_in.data))
        else $error("earlier pixel altered on capture");

    a_sof_even: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && pix_in.sof && !pix_in.eol |=> !line_odd_r)
        else $error("frame start did not give even line");

    a_line_toggle: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && pix_in.eol && !pix_in.sof |=>
            line_odd_r != $past(line_odd_r))
        else $error("line parity did not advance");

    a_eol_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && pix_in.eol && state_r == BGP_ST_SECOND |=>
            state_r == BGP_ST_FIRST && first_r)
        else $error("pairing not restarted at line end");

    a_flush_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_r == BGP_ST_FLUSH |-> !pix_ready && grp_valid && grp.last)
        else $error("odd tail group not flushed");

    a_pair_go: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && state_r == BGP_ST_FIRST && !pix_in.eol |=>
            state_r == BGP_ST_SECOND)
        else $error("earlier pixel not followed by pairing");

    a_sec_load: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && state_r == BGP_ST_SECOND |-> grp_valid && grp_ready)
        else $error("later pixel taken without its group");

    a_cnt_clr: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && pix_in.sof && !pix_in.eol |=> line_cnt_r == '0)
        else $error("line count not cleared at frame start");

    a_cnt_step: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && pix_in.eol && !pix_in.sof |=>
            line_cnt_r == $past(line_cnt_r) + CNT_W'(1))
        else $error("line count did not advance");

    a_no_tail: assert property (@(posedge sys_clk) disable iff (!nrst)
        pix_acc && pix_in.eol && state_r == BGP_ST_SECOND |=> !tail_r)
        else $error("tail flagged on a paired line end");

    a_mode_in: assert property (@(posedge sys_clk) disable iff (!nrst)
        !green_blue_first_twelve_bit_packed_mode |->
            !grp_valid || state_r == BGP_ST_FLUSH)
        else $error("group loaded with packed mode off");

    a_mode_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        !green_blue_first_twelve_bit_packed_mode |-> !pix_ready)
        else $error("pixel taken with packed mode off");

endmodule : bgp_packer

/* File: design/bgp_pkg.sv */
// shared types and constants of the twelve-bit mosaic pixel packer
// assumes one clock domain and a synchronous active-low reset
package bgp_pkg;

    localparam int unsigned PIX_W     = 12;
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned NIB_W     = 4;
    localparam int unsigned HI_LSB    = 4;
    localparam int unsigned HI_MSB    = 11;
    localparam int unsigned LO_MSB    = 3;
    localparam int unsigned CNT_W     = 16;

    localparam logic [11:0] PIX_MAX   = 12'hfff;
    localparam logic [11:0] PIX_ZERO  = 12'h000;

    typedef enum logic [1:0] {
        BGP_COL_GREEN = 2'h0,
        BGP_COL_BLUE  = 2'h1,
        BGP_COL_RED   = 2'h2
    } bgp_colour_t;

    // which byte of a three-byte group is on the output
    typedef enum logic [1:0] {
        BGP_PH_EARLY_HI = 2'h0,
        BGP_PH_MIXED_LO = 2'h1,
        BGP_PH_LATE_HI  = 2'h2
    } bgp_phase_t;

    typedef struct packed {
        logic [11:0] data;
        logic        sof;
        logic        eol;
    } bgp_pix_t;

    typedef struct packed {
        logic [11:0] early;
        logic [11:0] late;
        logic        odd_line;
        logic        first;
        logic        last;
    } bgp_grp_t;

    typedef struct packed {
        logic [7:0]  data;
        bgp_colour_t colour;
        logic        odd_line;
        logic        first;
        logic        last;
    } bgp_byte_t;

    localparam bgp_byte_t BYTE_RST = '{8'h00, BGP_COL_GREEN, 1'b0, 1'b0,
                                       1'b0};

    // mosaic colour of a pixel from line parity and position in the pair
    function automatic bgp_colour_t bgp_colour_of(input logic odd_line,
                                                  input logic late);
        if (odd_line) begin
            bgp_colour_of = late ? BGP_COL_GREEN : BGP_COL_RED;
        end else begin
            bgp_colour_of = late ? BGP_COL_BLUE : BGP_COL_GREEN;
        end
    endfunction : bgp_colour_of

endpackage : bgp_pkg

/* File: design/bgp_byte_emitter.sv */
// serialises one pixel pair into three bytes
// assumes groups come from the pairing logic on the same clock
`timescale 1ns/100ps
module bgp_byte_emitter (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              grp_valid,
    output logic                   grp_ready,
    input  wire bgp_pkg::bgp_grp_t grp_in,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output bgp_pkg::bgp_byte_t     out_byte
);
    import bgp_pkg::*;

    logic       full_r;
    logic       full_nxt;
    bgp_phase_t phase_r;
    bgp_phase_t phase_nxt;
    bgp_grp_t   grp_r;
    bgp_grp_t   grp_nxt;
    bgp_byte_t  byte_r;
    bgp_byte_t  byte_nxt;
    logic       take_out;

    assign take_out  = full_r && out_ready;
    assign grp_ready = !full_r || (take_out && phase_r == BGP_PH_LATE_HI);
    assign out_valid = full_r;
    assign out_byte  = byte_r;

    always_comb begin
        full_nxt  = full_r;
        phase_nxt = phase_r;
        grp_nxt   = grp_r;
        byte_nxt  = byte_r;
        if (grp_valid && grp_ready) begin
            // upper bits of the earlier pixel lead the group
            full_nxt  = 1'b1;
            phase_nxt = BGP_PH_EARLY_HI;
            grp_nxt   = grp_in;
            byte_nxt  = '{grp_in.early[HI_MSB:HI_LSB],
                          bgp_colour_of(grp_in.odd_line, 1'b0),
                          grp_in.odd_line, grp_in.first, 1'b0};
        end else if (take_out) begin
            case (phase_r)
                BGP_PH_EARLY_HI: begin
                    phase_nxt = BGP_PH_MIXED_LO;
                    byte_nxt  = '{{grp_r.late[LO_MSB:0],
                                   grp_r.early[LO_MSB:0]},
                                  bgp_colour_of(grp_r.odd_line, 1'b0),
                                  grp_r.odd_line, 1'b0, 1'b0};
                end
                BGP_PH_MIXED_LO: begin
                    phase_nxt = BGP_PH_LATE_HI;
                    byte_nxt  = '{grp_r.late[HI_MSB:HI_LSB],
                                  bgp_colour_of(grp_r.odd_line, 1'b1),
                                  grp_r.odd_line, 1'b0, grp_r.last};
                end
                default: begin
                    full_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            full_r  <= 1'b0;
            phase_r <= BGP_PH_EARLY_HI;
            grp_r   <= '0;
            byte_r  <= BYTE_RST;
        end else begin
            full_r  <= full_nxt;
            phase_r <= phase_nxt;
            grp_r   <= grp_nxt;
            byte_r  <= byte_nxt;
        end
    end

    a_byte0_upper: assert property (@(posedge sys_clk) disable iff (!nrst)
        grp_valid && grp_ready |=>
            out_valid && out_byte.data == $past(grp_in.early[HI_MSB:HI_LSB]))
        else $error("first byte is not upper bits of earlier pixel");

    a_mid_nibbles: assert property (@(posedge sys_clk) disable iff (!nrst)
        take_out && phase_r == BGP_PH_EARLY_HI |=>
            out_byte.data == {grp_r.late[LO_MSB:0], grp_r.early[LO_MSB:0]})
        else $error("middle byte nibbles misplaced");

    a_last_upper: assert property (@(posedge sys_clk) disable iff (!nrst)
        take_out && phase_r == BGP_PH_MIXED_LO |=>
            out_byte.data == grp_r.late[HI_MSB:HI_LSB]
            && out_byte.last == grp_r.last)
        else $error("last byte is not upper bits of later pixel");

    a_stall_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        out_valid && !out_ready |=> out_valid && $stable(out_byte))
        else $error("byte changed while stalled");

    a_even_colour: assert property (@(posedge sys_clk) disable iff (!nrst)
        out_valid && !out_byte.odd_line |->
            out_byte.colour == ((phase_r == BGP_PH_LATE_HI) ? BGP_COL_BLUE
                                                           : BGP_COL_GREEN))
        else $error("even line colour order wrong");

    a_odd_colour: assert property (@(posedge sys_clk) disable iff (!nrst)
        out_valid && out_byte.odd_line |->
            out_byte.colour == ((phase_r == BGP_PH_LATE_HI) ? BGP_COL_GREEN
                                                           : BGP_COL_RED))
        else $error("odd line colour order wrong");

endmodule : bgp_byte_emitter

/* File: testbench/bgp_host_sink.sv */
// host image buffer model: takes bytes off the packer, stalling at random
// assumes the packer's valid/ready byte handshake on sys_clk
`timescale 1ns/100ps
module bgp_host_sink (
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic               stall_en,
    input  wire logic               out_valid,
    output logic                    out_ready,
    input  wire bgp_pkg::bgp_byte_t out_byte
);
    import bgp_pkg::*;
    bgp_byte_t got[$];

    // bytes land in buffer order, one per accepting edge
    always @(posedge sys_clk) begin
        if (nrst && out_valid && out_ready) begin
            got.push_back(out_byte);
        end
        out_ready <= !stall_en || ($urandom_range(0, 2) != 0);
    end
endmodule : bgp_host_sink

/* File: testbench/tb_bgp_packer.sv */
// self-checking bench of the mosaic pixel packer: random lines and stalls
// assumes the design package and the host sink model
`timescale 1ns/100ps
module tb_bgp_packer;
    import bgp_pkg::*;
    logic        sys_clk   = 1'b0;
    logic        nrst      = 1'b0;
    logic        mode      = 1'b1;
    logic        pix_valid = 1'b0;
    logic        pix_ready;
    bgp_pix_t    pix_in    = '0;
    logic        out_valid;
    logic        out_ready;
    bgp_byte_t   out_byte;
    logic        line_odd;
    logic [15:0] line_count;
    logic        odd_tail;
    logic        tail_seen = 1'b0;
    logic        stall_en  = 1'b0;
    int          miscompares = 0;
    int          checked     = 0;
    bgp_byte_t   exp_q[$];

    always #4 sys_clk = ~sys_clk;

    bgp_packer i_dut (
        .sys_clk                                 (sys_clk),
        .nrst                                    (nrst),
        .green_blue_first_twelve_bit_packed_mode (mode),
        .pix_valid                               (pix_valid),
        .pix_ready                               (pix_ready),
        .pix_in                                  (pix_in),
        .out_valid                               (out_valid),
        .out_ready                               (out_ready),
        .out_byte                                (out_byte),
        .line_odd                                (line_odd),
        .line_count                              (line_count),
        .odd_tail                                (odd_tail)
    );

    // no line of even width may leave a tail flag
    always @(posedge sys_clk) begin
        if (odd_tail === 1'b1) begin
            tail_seen <= 1'b1;
        end
    end

    bgp_host_sink i_sink (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .stall_en  (stall_en),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_byte  (out_byte)
    );

    task check(string what, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task tally_and_finish();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // drives one line back to back, queues the bytes the host must see
    task send_line(int w, logic sof, logic odd);
        logic [11:0] e;
        logic [11:0] d;
        logic        rdy;
        int          n;
        bgp_colour_t ce;
        bgp_colour_t cl;
        ce = odd ? BGP_COL_RED : BGP_COL_GREEN;
        cl = odd ? BGP_COL_GREEN : BGP_COL_BLUE;
        e = 12'h000;
        @(posedge sys_clk);
        for (int i = 0; i < w; i++) begin
            d = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
            pix_valid <= 1'b1;
            pix_in    <= '{d, sof && i == 0, i == w - 1};
            n = 0;
            do begin
                @(negedge sys_clk);
                rdy = pix_ready;
                @(posedge sys_clk);
                n++;
            end while (rdy !== 1'b1 && n < 500);
            if (i % 2 == 0) begin
                e = d;
            end else begin
                exp_q.push_back('{e[11:4], ce, odd, i == 1, 1'b0});
                exp_q.push_back('{{d[3:0], e[3:0]}, ce, odd, 1'b0, 1'b0});
                exp_q.push_back('{d[11:4], cl, odd, 1'b0, i == w - 1});
            end
        end
        pix_valid <= 1'b0;
    endtask : send_line

    initial begin
        int nl;
        int w;
        void'($urandom(32'haf8d3f46));
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        check("line_count reset", line_count, 16'h0000);
        for (int f = 0; f < 2; f++) begin
            nl = 3 - f;
            for (int l = 0; l < nl; l++) begin
                w = (f == 0 && l == 0) ? 2 : 2 * $urandom_range(1, 12);
                stall_en <= (f + l) != 0;
                send_line(w, l == 0, l[0]);
            end
            for (int k = 0; k < 2000; k++) begin
                if (i_sink.got.size() >= exp_q.size()) begin
                    break;
                end
                @(posedge sys_clk);
            end
            check("line_count", line_count, 16'(nl));
            check("line_odd", {15'h0, line_odd}, 16'(nl % 2));
        end
        mode      <= 1'b0;
        pix_valid <= 1'b1;
        pix_in    <= '{12'h5a5, 1'b1, 1'b0};
        @(negedge sys_clk);
        check("pix_ready mode off", {15'h0, pix_ready}, 16'h0000);
        @(posedge sys_clk);
        pix_valid <= 1'b0;
        mode      <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("bytes", 16'(i_sink.got.size()), 16'(exp_q.size()));
        check("odd_tail", {15'h0, tail_seen}, 16'h0000);
        foreach (exp_q[i]) begin
            if (i < i_sink.got.size()) begin
                check("byte", {3'h0, i_sink.got[i]}, {3'h0, exp_q[i]});
            end
        end
        tally_and_finish();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : tb_bgp_packer
